// [hdl/cgmc_defs.vh]
`ifndef CGMC_DEFS_VH
`define CGMC_DEFS_VH
// register addresses
`define CGMC_ADDR_STATUS 3'h0
`define CGMC_ADDR_LOOP 3'h1
`define CGMC_ADDR_MODE 3'h2
`define CGMC_ADDR_REF 3'h3
// status/control fields
`define CGMC_SC_LOSS 7
`define CGMC_SC_LOCK 6
`define CGMC_SC_PLLST 5
`define CGMC_SC_IREFST 4
`define CGMC_SC_CLOCK_MODE_STATUS_FIELD 3:2
`define CGMC_SC_OSCRDY 1
`define CGMC_SC_FINE_TRIM_BIT 0
// loop control fields
`define CGMC_LC_IRQEN 7
`define CGMC_LC_PLLSEL 6
`define CGMC_LC_CMEN 5
`define CGMC_LC_MULT 3:0
`define CGMC_LC_RESET 8'h01
`define CGMC_LC_WMASK 8'hEF
// mode control fields
`define CGMC_MC_CLKSEL 7:6
`define CGMC_MC_IREF 5
`define CGMC_MC_REF_DIVIDER_FIELD 4:2
`define CGMC_MC_LP 1
`define CGMC_MC_RESET 8'h20
`define CGMC_MC_WMASK 8'hFE
// reference control fields
`define CGMC_RC_EXT_REF_ENABLE 1
`define CGMC_RC_OSCSEL 0
`define CGMC_RC_BITS 1:0
`define CGMC_RC_RESET 2'h0
// clock select and status encodings
`define CGMC_SEL_FLL 2'h0
`define CGMC_SEL_INT 2'h1
`define CGMC_SEL_EXT 2'h2
`define CGMC_SEL_PLL 2'h3
`define CGMC_DIV_NONE 3'h0
// multiplier codes and factors
`define CGMC_MULT_MAX_CODE 4'hA
`define CGMC_MULT_MAX 6'h28
`define CGMC_MULT_RSVD 6'h00
`define CGMC_FLL_FACTOR 11'h400
// timing
`define CGMC_CLK_NS 40
`define CGMC_OSC_START_EDGES 4096
`define CGMC_CM_LOSS_NS 4000
`endif

// [hdl/cgmc_top.v]
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "cgmc_defs.vh"
module cgmc_top #(
    parameter ADDR_W = 3,
    parameter START_EDGES = `CGMC_OSC_START_EDGES,
    parameter CM_LOSS_CYC = `CGMC_CM_LOSS_NS / `CGMC_CLK_NS
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire ext_ref_clk,
    input wire fll_locked,
    input wire pll_locked,
    input wire stop_req,
    output reg [1:0] main_output_clock_sel_q,
    output reg debug_link_clock_fll_q,
    output reg fll_enable_q,
    output reg pll_enable_q,
    output reg ref_internal_q,
    output reg [2:0] ref_divider_q,
    output reg [10:0] fll_factor_q,
    output reg [5:0] pll_factor_q,
    output reg fine_trim_bit_q,
    output reg osc_enable_q,
    output reg lock_loss_irq_q,
    output reg clock_monitor_reset_q,
    output reg [8:0] mode_q
);
    // one-hot operating states
    localparam [8:0] ST_FEI = 9'h001;
    localparam [8:0] ST_FEE = 9'h002;
    localparam [8:0] ST_FBI = 9'h004;
    localparam [8:0] ST_FBE = 9'h008;
    localparam [8:0] ST_PEE = 9'h010;
    localparam [8:0] ST_PBE = 9'h020;
    localparam [8:0] ST_LOWPOWER_INTERNAL_BYPASS_MODE = 9'h040;
    localparam [8:0] ST_LOWPOWER_EXTERNAL_BYPASS_MODE = 9'h080;
    localparam [8:0] ST_STOP = 9'h100;

    // multiplier code to factor
    function [5:0] mult_factor;
        input [3:0] code;
        begin
            if (code == 4'h0)
                mult_factor = `CGMC_MULT_RSVD; // reserved code
            else if (code > `CGMC_MULT_MAX_CODE)
                mult_factor = `CGMC_MULT_MAX;
            else
                mult_factor = {code, 2'b00};
        end
    endfunction

    // target state from clock select, reference select, low-power and PLL select bits together
    function [8:0] decode_mode;
        input [1:0] clock_select_field;
        input internal_ref_select;
        input loop_select_bit;
        input lp;
        begin
            case (clock_select_field)
                `CGMC_SEL_FLL: decode_mode = internal_ref_select ? ST_FEI : (loop_select_bit ? ST_PEE : ST_FEE);
                `CGMC_SEL_INT: decode_mode = lp ? ST_LOWPOWER_INTERNAL_BYPASS_MODE : ST_FBI;
                `CGMC_SEL_EXT: decode_mode = lp ? ST_LOWPOWER_EXTERNAL_BYPASS_MODE : (loop_select_bit ? ST_PBE : ST_FBE);
                default: decode_mode = ST_FEI;
            endcase
        end
    endfunction

    // permitted state pairs
    function allowed;
        input [8:0] a;
        input [8:0] b;
        reg [17:0] p;
        begin
            p = {a, b};
            case (p)
                {ST_FEI, ST_FEE}, {ST_FEE, ST_FEI}, {ST_FEI, ST_FBI}, {ST_FBI, ST_FEI},
                {ST_FEI, ST_FBE}, {ST_FBE, ST_FEI}, {ST_FEE, ST_FBI}, {ST_FBI, ST_FEE},
                {ST_FEE, ST_FBE}, {ST_FBE, ST_FEE}, {ST_FBI, ST_FBE}, {ST_FBE, ST_FBI},
                {ST_FBI, ST_LOWPOWER_INTERNAL_BYPASS_MODE}, {ST_LOWPOWER_INTERNAL_BYPASS_MODE, ST_FBI}, {ST_FBE, ST_PBE}, {ST_PBE, ST_FBE},
                {ST_FBE, ST_LOWPOWER_EXTERNAL_BYPASS_MODE}, {ST_LOWPOWER_EXTERNAL_BYPASS_MODE, ST_FBE}, {ST_PBE, ST_PEE}, {ST_PEE, ST_PBE},
                {ST_PBE, ST_LOWPOWER_EXTERNAL_BYPASS_MODE}, {ST_LOWPOWER_EXTERNAL_BYPASS_MODE, ST_PBE}: allowed = 1'b1;
                default: allowed = 1'b0;
            endcase
        end
    endfunction

    // software registers
    reg loss_q;
    reg osc_rdy_q;
    reg [7:0] loop_q;
    reg [7:0] mode_ctl_q;
    reg [1:0] ref_ctl_q;
    reg [8:0] resume_q;
    reg [8:0] mode_d;
    // status pipeline for cross-domain report
    reg [1:0] clock_mode_status_field_s1_q;
    reg [1:0] clock_mode_status_field_q;
    reg irefst_s1_q;
    reg irefst_q;
    reg pllst_s1_q;
    reg pllst_q;
    // synchronisers
    reg [2:0] ext_sync_q;
    reg [1:0] fll_lk_sync_q;
    reg [1:0] pll_lk_sync_q;
    reg was_locked_q;
    reg [12:0] start_cnt_q;
    reg [12:0] cm_cnt_q;
    reg ext_seen_q;

    wire ext_edge = ext_sync_q[1] & ~ext_sync_q[2];
    wire ext_mode = |(mode_q & (ST_FEE | ST_FBE | ST_PEE | ST_PBE | ST_LOWPOWER_EXTERNAL_BYPASS_MODE));
    wire int_mode = |(mode_q & (ST_FEI | ST_FBI | ST_LOWPOWER_INTERNAL_BYPASS_MODE));
    wire ext_req = ref_ctl_q[`CGMC_RC_EXT_REF_ENABLE] | ext_mode;
    wire osc_sel = ref_ctl_q[`CGMC_RC_OSCSEL];
    wire osc_clr = ~osc_sel | (int_mode & ~ref_ctl_q[`CGMC_RC_EXT_REF_ENABLE]);
    wire ext_avail = osc_sel ? osc_rdy_q : ext_seen_q;
    wire loop_select_bit = loop_q[`CGMC_LC_PLLSEL];
    wire [8:0] target = decode_mode(mode_ctl_q[`CGMC_MC_CLKSEL], mode_ctl_q[`CGMC_MC_IREF], loop_select_bit,
                                    mode_ctl_q[`CGMC_MC_LP]);
    wire tgt_ext = |(target & (ST_FEE | ST_FBE | ST_PEE | ST_PBE | ST_LOWPOWER_EXTERNAL_BYPASS_MODE));
    wire fll_on = |(mode_q & (ST_FEI | ST_FEE | ST_FBI | ST_FBE)) & ~loop_select_bit;
    wire pll_on = |(mode_q & (ST_PEE | ST_PBE)) & loop_select_bit;
    wire locked_now = fll_on ? fll_lk_sync_q[1] : pll_lk_sync_q[1];
    wire loss_set = (fll_on | pll_on) & was_locked_q & ~locked_now;
    wire loss_clr = reg_wr & (reg_addr == `CGMC_ADDR_STATUS) & reg_wdata[`CGMC_SC_LOSS];
    wire [1:0] src_sel = (mode_q == ST_PEE) ? `CGMC_SEL_PLL :
                         (|(mode_q & (ST_FEI | ST_FEE))) ? `CGMC_SEL_FLL :
                         (|(mode_q & (ST_FBI | ST_LOWPOWER_INTERNAL_BYPASS_MODE))) ? `CGMC_SEL_INT : `CGMC_SEL_EXT;

    // pin and analog status synchronisers
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sync_q <= 3'h0;
            fll_lk_sync_q <= 2'h0;
            pll_lk_sync_q <= 2'h0;
        end
        else
        begin
            ext_sync_q <= {ext_sync_q[1:0], ext_ref_clk};
            fll_lk_sync_q <= {fll_lk_sync_q[0], fll_locked};
            pll_lk_sync_q <= {pll_lk_sync_q[0], pll_locked};
        end
    end

    // register writes and sticky flags
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loop_q <= `CGMC_LC_RESET;
            mode_ctl_q <= `CGMC_MC_RESET;
            ref_ctl_q <= `CGMC_RC_RESET;
            fine_trim_bit_q <= 1'b0;
            loss_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `CGMC_ADDR_STATUS)
                fine_trim_bit_q <= reg_wdata[`CGMC_SC_FINE_TRIM_BIT];
            if (reg_wr && reg_addr == `CGMC_ADDR_LOOP)
                loop_q <= reg_wdata & `CGMC_LC_WMASK; // unused bit reads back 0
            if (reg_wr && reg_addr == `CGMC_ADDR_MODE)
                mode_ctl_q <= reg_wdata & `CGMC_MC_WMASK;
            if (reg_wr && reg_addr == `CGMC_ADDR_REF)
                ref_ctl_q <= reg_wdata[`CGMC_RC_BITS];
            // set wins over a write-one clear
            if (loss_set)
                loss_q <= 1'b1;
            else if (loss_clr)
                loss_q <= 1'b0;
        end
    end

    // lock tracking: armed once the running loop has locked
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            was_locked_q <= 1'b0;
        else if (!(fll_on | pll_on) || mode_d != mode_q)
            was_locked_q <= 1'b0;
        else if (locked_now)
            was_locked_q <= 1'b1;
        else if (loss_set)
            was_locked_q <= 1'b0;
    end

    // oscillator start-up count and ready flag
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_cnt_q <= 13'h0;
            osc_rdy_q <= 1'b0;
            ext_seen_q <= 1'b0;
        end
        else
        begin
            if (osc_clr)
                osc_rdy_q <= 1'b0;
            else if (ext_req && osc_sel && start_cnt_q == START_EDGES[12:0])
                osc_rdy_q <= 1'b1;
            if (!ext_req || osc_clr)
                start_cnt_q <= 13'h0;
            else if (ext_edge && start_cnt_q != START_EDGES[12:0])
                start_cnt_q <= start_cnt_q + 13'h1;
            if (!ext_req || cm_cnt_q == CM_LOSS_CYC[12:0])
                ext_seen_q <= 1'b0;
            else if (ext_edge)
                ext_seen_q <= 1'b1;
        end
    end

    // external clock monitor
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cm_cnt_q <= 13'h0;
            clock_monitor_reset_q <= 1'b0;
        end
        else
        begin
            if (!ext_req || ext_edge)
                cm_cnt_q <= 13'h0;
            else if (cm_cnt_q != CM_LOSS_CYC[12:0])
                cm_cnt_q <= cm_cnt_q + 13'h1;
            // held until the system reset it causes
            if (loop_q[`CGMC_LC_CMEN] && ext_req && cm_cnt_q == CM_LOSS_CYC[12:0])
                clock_monitor_reset_q <= 1'b1;
        end
    end

    // next state: stop overrides, else permitted move once source ready
    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            ST_STOP:
                if (!stop_req)
                    mode_d = resume_q;
            default:
                if (stop_req)
                    mode_d = ST_STOP;
                else if (target != mode_q && allowed(mode_q, target) && (!tgt_ext || ext_avail))
                    mode_d = target;
        endcase
    end

    // mode register and resume point
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= ST_FEI;
            resume_q <= ST_FEI;
        end
        else
        begin
            mode_q <= mode_d;
            if (mode_d == ST_STOP && mode_q != ST_STOP)
                resume_q <= mode_q;
        end
    end

    // clock routing outputs
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_output_clock_sel_q <= `CGMC_SEL_FLL;
            debug_link_clock_fll_q <= 1'b1;
            fll_enable_q <= 1'b1;
            pll_enable_q <= 1'b0;
            ref_internal_q <= 1'b1;
            ref_divider_q <= `CGMC_DIV_NONE;
            fll_factor_q <= `CGMC_FLL_FACTOR;
            pll_factor_q <= `CGMC_MULT_MAX;
            osc_enable_q <= 1'b0;
            lock_loss_irq_q <= 1'b0;
        end
        else
        begin
            main_output_clock_sel_q <= src_sel;
            debug_link_clock_fll_q <= fll_on;
            fll_enable_q <= fll_on;
            pll_enable_q <= pll_on;
            ref_internal_q <= |(mode_q & (ST_FEI | ST_FBI | ST_LOWPOWER_INTERNAL_BYPASS_MODE));
            ref_divider_q <= mode_ctl_q[`CGMC_MC_REF_DIVIDER_FIELD];
            fll_factor_q <= `CGMC_FLL_FACTOR;
            pll_factor_q <= mult_factor(loop_q[`CGMC_LC_MULT]);
            osc_enable_q <= ext_req & (mode_q != ST_STOP);
            lock_loss_irq_q <= loss_q & loop_q[`CGMC_LC_IRQEN];
        end
    end

    // CLKST and PLLST lag two cycles, IREFST three, for the domain crossing
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_mode_status_field_s1_q <= `CGMC_SEL_FLL;
            clock_mode_status_field_q <= `CGMC_SEL_FLL;
            irefst_s1_q <= 1'b1;
            irefst_q <= 1'b1;
            pllst_s1_q <= 1'b0;
            pllst_q <= 1'b0;
        end
        else
        begin
            clock_mode_status_field_s1_q <= src_sel;
            clock_mode_status_field_q <= clock_mode_status_field_s1_q;
            irefst_s1_q <= ref_internal_q;
            irefst_q <= irefst_s1_q;
            pllst_s1_q <= loop_select_bit;
            pllst_q <= pllst_s1_q;
        end
    end

    // read port: data in the cycle after the strobe only
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_q <= 8'h00;
        else if (!reg_rd)
            reg_rdata_q <= 8'h00;
        else
        begin
            case (reg_addr)
                `CGMC_ADDR_STATUS: reg_rdata_q <= {loss_q, locked_now & (fll_on | pll_on), pllst_q,
                                                   irefst_q, clock_mode_status_field_q, osc_rdy_q, fine_trim_bit_q};
                `CGMC_ADDR_LOOP: reg_rdata_q <= loop_q;
                `CGMC_ADDR_MODE: reg_rdata_q <= mode_ctl_q;
                `CGMC_ADDR_REF: reg_rdata_q <= {6'h00, ref_ctl_q};
                default: reg_rdata_q <= 8'h00; // unmapped
            endcase
        end
    end
endmodule // cgmc_top

// [verification/cgmc_osc_model.sv]
`timescale 1ns/10ps
// crystal or external clock at the reference pin
module cgmc_osc_model #(
    parameter HALF_NS = 55
) (
    input wire run,
    input wire stall,
    output logic ext_ref_clk
);
    // toggles only while requested and not stalled, rests low otherwise
    initial ext_ref_clk = 1'b0;
    always
    begin
        #HALF_NS;
        ext_ref_clk = (run && !stall) ? !ext_ref_clk : 1'b0;
    end
endmodule // cgmc_osc_model

// [verification/cgmc_check_sva.sv]
`timescale 1ns/10ps
// watches the mode outputs and register side effects of the clock block
module cgmc_sva #(
    parameter ADDR_W = 3
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire [1:0] main_output_clock_sel_q,
    input wire debug_link_clock_fll_q,
    input wire fll_enable_q,
    input wire pll_enable_q,
    input wire ref_internal_q,
    input wire [10:0] fll_factor_q,
    input wire [5:0] pll_factor_q,
    input wire lock_loss_irq_q,
    input wire clock_monitor_reset_q,
    input wire [8:0] mode_q
);
    // factor expected for a multiplier code
    function automatic [5:0] mult_f(input [7:0] c);
        mult_f = (c[3:0] == 4'h0) ? 6'h00 : (c[3:0] > 4'hA) ? 6'h28 : {c[3:0], 2'h0};
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // mode outputs and loop exclusivity
    a_loop_excl: assert property (!(fll_enable_q && pll_enable_q))
        else $error("both loops enabled");
    a_fei_out: assert property ($stable(mode_q) && mode_q == 9'h001 |->
        main_output_clock_sel_q == 2'h0 && ref_internal_q) else $error("bad outputs in fei");
    a_fbi_out: assert property ($stable(mode_q) && mode_q == 9'h004 |->
        main_output_clock_sel_q == 2'h1 && ref_internal_q && fll_enable_q && debug_link_clock_fll_q
        && !pll_enable_q) else $error("bad outputs in fbi");
    a_fee_out: assert property ($stable(mode_q) && mode_q == 9'h002 |->
        main_output_clock_sel_q == 2'h0 && !ref_internal_q && fll_enable_q && !pll_enable_q)
        else $error("bad outputs in fee");
    a_fll_factor: assert property (fll_factor_q == 11'h400)
        else $error("fll factor not 1024");
    // register writes and their effects, and the sticky monitor reset
    a_mult_code: assert property (reg_wr && reg_addr == 3'h1 |=> ##1
        pll_factor_q == mult_f($past(reg_wdata, 2))) else $error("pll factor wrong");
    a_mode_fbi: assert property (reg_wr && reg_addr == 3'h2 && reg_wdata == 8'h60
        && mode_q == 9'h001 |=> ##1 mode_q == 9'h004) else $error("fbi not entered");
    a_irq_gate: assert property (reg_wr && reg_addr == 3'h1 && !reg_wdata[7]
        |=> ##1 !lock_loss_irq_q) else $error("irq without enable");
    a_cm_sticky: assert property (clock_monitor_reset_q |=> clock_monitor_reset_q)
        else $error("monitor reset dropped");
endmodule // cgmc_sva

bind cgmc_top cgmc_sva #(.ADDR_W(ADDR_W)) i_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .main_output_clock_sel_q(main_output_clock_sel_q), .debug_link_clock_fll_q(debug_link_clock_fll_q),
    .fll_enable_q(fll_enable_q), .pll_enable_q(pll_enable_q), .ref_internal_q(ref_internal_q),
    .fll_factor_q(fll_factor_q), .pll_factor_q(pll_factor_q), .lock_loss_irq_q(lock_loss_irq_q),
    .clock_monitor_reset_q(clock_monitor_reset_q), .mode_q(mode_q)
);

// [verification/clock_generator_mode_control_test.sv]
`timescale 1ns/10ps
module clock_generator_mode_control_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, fll_locked = 1'b0, stall = 1'b0;
    wire ext_ref_clk, dbg, fll_en, pll_en, ref_int, trim, osc_en, irq, cm_rst;
    wire [7:0] reg_rdata_q;
    wire [1:0] sel;
    wire [10:0] fll_f;
    wire [5:0] pll_f;
    wire [8:0] mode;
    wire [2:0] ref_divider_field;
    int num_errors = 0, check_count = 0;
    logic [7:0] v = 8'h00;

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    cgmc_top #(.START_EDGES(8), .CM_LOSS_CYC(20)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ext_ref_clk(ext_ref_clk),
        .fll_locked(fll_locked), .pll_locked(1'b0), .stop_req(1'b0),
        .main_output_clock_sel_q(sel), .debug_link_clock_fll_q(dbg), .fll_enable_q(fll_en),
        .pll_enable_q(pll_en), .ref_internal_q(ref_int), .ref_divider_q(ref_divider_field), .fll_factor_q(fll_f),
        .pll_factor_q(pll_f), .fine_trim_bit_q(trim), .osc_enable_q(osc_en),
        .lock_loss_irq_q(irq), .clock_monitor_reset_q(cm_rst), .mode_q(mode)
    );

    cgmc_osc_model i_osc (.run(osc_en), .stall(stall), .ext_ref_clk(ext_ref_clk));

    // verdict and end of run
    task automatic results;
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // compare and count
    task automatic chk(input [10:0] got, input [10:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // register bus cycles
    task automatic wr(input [2:0] a, input [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input [2:0] a, output [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask

    task automatic rdc(input [2:0] a, input [7:0] m, input [7:0] e);
        rd(a, v);
        chk(v & m, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(3'h1, 8'hFF, 8'h01);
        rdc(3'h2, 8'hFF, 8'h20);
        rdc(3'h3, 8'hFF, 8'h00);
        rdc(3'h5, 8'hFF, 8'h00);
        rdc(3'h0, 8'h1E, 8'h10);
        chk(mode, 9'h001);
        chk({sel, fll_en, pll_en, dbg}, 5'h05);
        wr(3'h0, 8'h01);
        cyc(1);
        chk(trim, 1'b1);
        wr(3'h0, 8'h00);
        cyc(1);
        chk(trim, 1'b0);
        for (int c = 0; c < 16; c++)
        begin
            wr(3'h1, 8'(c));
            cyc(2);
            chk(pll_f, 11'((c == 0) ? 0 : (c > 10) ? 40 : 4 * c));
        end
        wr(3'h1, 8'h41);
        cyc(3);
        chk(fll_en, 1'b0);
        // pll engaged target is not a permitted move from the default mode
        wr(3'h2, 8'h00);
        cyc(3);
        chk(mode, 9'h001);
        wr(3'h2, 8'h20);
        wr(3'h1, 8'h01);
        cyc(3);
        chk({fll_en, pll_en}, 2'h2);
        // lock gained then lost
        @(posedge sys_clk) fll_locked <= 1'b1;
        cyc(6);
        @(posedge sys_clk) fll_locked <= 1'b0;
        cyc(6);
        rdc(3'h0, 8'h80, 8'h80);
        chk(irq, 1'b0);
        wr(3'h0, 8'h00);
        rdc(3'h0, 8'h80, 8'h80);
        wr(3'h1, 8'h81);
        cyc(2);
        chk(irq, 1'b1);
        // enable dropped while the flag stays set
        wr(3'h1, 8'h01);
        cyc(2);
        chk(irq, 1'b0);
        wr(3'h1, 8'h81);
        wr(3'h0, 8'h80);
        cyc(2);
        chk(irq, 1'b0);
        rdc(3'h0, 8'h80, 8'h00);
        wr(3'h1, 8'h01);
        // bypassed internal and back
        wr(3'h2, 8'h60);
        cyc(2);
        chk(mode, 9'h004);
        chk({sel, fll_en, pll_en, dbg}, 5'h0D);
        cyc(3);
        rdc(3'h0, 8'h0C, 8'h04);
        wr(3'h2, 8'h20);
        cyc(2);
        chk(mode, 9'h001);
        // oscillator start-up, then external modes
        wr(3'h3, 8'h03);
        v = 8'h00;
        for (int i = 0; i < 100 && !v[1]; i++)
            rd(3'h0, v);
        chk(v[1], 1'b1);
        if (!v[1])
            results;
        chk(osc_en, 1'b1);
        wr(3'h2, 8'h0C);
        cyc(2);
        chk(mode, 9'h002);
        chk(ref_divider_field, 3'h3);
        cyc(1);
        chk({sel, ref_int, fll_en, pll_en}, 5'h02);
        wr(3'h2, 8'h80);
        cyc(6);
        rdc(3'h0, 8'h0C, 8'h08);
        chk(sel, 2'h2);
        wr(3'h2, 8'h00);
        cyc(2);
        wr(3'h2, 8'h20);
        cyc(2);
        chk(mode, 9'h001);
        rdc(3'h0, 8'h02, 8'h02);
        wr(3'h3, 8'h01);
        cyc(3);
        rdc(3'h0, 8'h02, 8'h00);
        // external clock lost, monitor off then on
        wr(3'h3, 8'h03);
        cyc(30);
        @(posedge sys_clk) stall <= 1'b1;
        cyc(40);
        chk(cm_rst, 1'b0);
        wr(3'h1, 8'h21);
        cyc(30);
        chk(cm_rst, 1'b1);
        @(posedge sys_clk) rst_n <= 1'b0;
        cyc(2);
        @(posedge sys_clk) rst_n <= 1'b1;
        cyc(1);
        chk({cm_rst, mode}, 10'h001);
        results;
    end
endmodule // clock_generator_mode_control_test
